// [include/led_gpio_pkg.sv]
/*
 * Shared constants for the GPIO LED driver, interrupt and clock block:
 * register indices, field positions, reset values, log intensity table.
 * Assumes an APB master with 32-bit data; byte address is index times 4.
 */
package led_gpio_pkg;
	localparam int NUM_IO = 4;
	// Register indices
	localparam logic [5:0] REG_POL = 6'h06;
	localparam logic [5:0] REG_DATA = 6'h08;
	localparam logic [5:0] REG_MASK = 6'h09;
	localparam logic [5:0] REG_SENSE = 6'h0A;
	localparam logic [5:0] REG_SRC = 6'h0B;
	localparam logic [5:0] REG_EVT = 6'h0C;
	localparam logic [5:0] REG_CLOCK = 6'h0D;
	localparam logic [5:0] REG_MISC = 6'h0E;
	localparam logic [5:0] REG_LEDEN = 6'h0F;
	// First LED register of each I/O; order on, on level, off, rise, fall
	localparam logic [5:0] ON_BASE [NUM_IO] =
		'{6'h12, 6'h15, 6'h1A, 6'h1F};
	localparam logic [2:0] SUB_ON = 3'h0;
	localparam logic [2:0] SUB_ONINT = 3'h1;
	localparam logic [2:0] SUB_OFF = 3'h2;
	localparam logic [2:0] SUB_RISE = 3'h3;
	localparam logic [2:0] SUB_FALL = 3'h4;
	// Capabilities per I/O
	localparam logic [NUM_IO-1:0] BLINK_IO = 4'hF;
	localparam logic [NUM_IO-1:0] FADE_IO = 4'hE;
	// Misc settings fields
	localparam int MISC_AUTOCLR = 0;
	localparam int MISC_RSTEN = 2;
	localparam int MISC_LOG = 3;
	localparam int MISC_CLK_LO = 4;
	// Clock management fields
	localparam int CLK_DIV_LO = 0;
	localparam int CLK_PIN_OUT = 4;
	localparam int CLK_SRC_LO = 5;
	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_INT = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [3:0] DIV_LOW = 4'h0;
	localparam logic [3:0] DIV_HIGH = 4'hF;
	// Edge sense codes
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	// Reset values and clear-all mask
	localparam logic [7:0] RST_ALL1 = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] CLR_ALL = 8'hFF;
	// Log map indexed by linear level divided by two
	localparam logic [7:0] LOG_LUT [128] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h02, 8'h02, 8'h02, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03,
		8'h04, 8'h04, 8'h05, 8'h05, 8'h06, 8'h06, 8'h07, 8'h07,
		8'h08, 8'h08, 8'h09, 8'h09, 8'h0A, 8'h0A, 8'h0B, 8'h0C,
		8'h0D, 8'h0D, 8'h0E, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13,
		8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B,
		8'h1C, 8'h1E, 8'h1F, 8'h20, 8'h22, 8'h23, 8'h24, 8'h26,
		8'h27, 8'h29, 8'h2A, 8'h2C, 8'h2E, 8'h2E, 8'h31, 8'h31,
		8'h35, 8'h35, 8'h38, 8'h38, 8'h3C, 8'h3C, 8'h41, 8'h41,
		8'h45, 8'h45, 8'h49, 8'h49, 8'h4E, 8'h4E, 8'h53, 8'h53,
		8'h58, 8'h58, 8'h5D, 8'h5D, 8'h62, 8'h62, 8'h68, 8'h68,
		8'h6E, 8'h6E, 8'h74, 8'h74, 8'h7A, 8'h7A, 8'h81, 8'h81,
		8'h87, 8'h87, 8'h8E, 8'h8E, 8'h96, 8'h96, 8'h9D, 8'h9D,
		8'hA5, 8'hA5, 8'hAC, 8'hAC, 8'hB5, 8'hB5, 8'hBD, 8'hBD,
		8'hC6, 8'hC6, 8'hCF, 8'hCF, 8'hD8, 8'hD8, 8'hE1, 8'hE1,
		8'hEB, 8'hEB, 8'hF5, 8'hF5, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
endpackage : led_gpio_pkg

// [src/led_channel.sv]
/*
 * One LED driver channel: static, single-shot and blink sequencing,
 * optional fading and log mapping, PWM compare.
 * Assumes ledTick and periodTick are one-cycle enables from the top.
 */
`timescale 1ns/1ps
module led_channel
	import led_gpio_pkg::*;
#(
	parameter bit CAN_BLINK = 1'b1,
	parameter bit CAN_FADE = 1'b1
)(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic restart,
	input wire logic ledTick,
	input wire logic periodTick,
	input wire logic run,
	input wire logic dataLow,
	input wire logic [7:0] onTime,
	input wire logic [7:0] onInt,
	input wire logic [7:0] offReg,
	input wire logic [7:0] fadeIn,
	input wire logic [7:0] fadeOut,
	input wire logic logMode,
	input wire logic [7:0] pwmCnt,
	output logic pwmOn
);
	typedef enum {IDLE, ON_PH, OFF_PH, HOLD} seq_t;
	seq_t state_q;
	logic [7:0] timer_q;
	logic [7:0] cur_q;
	logic [7:0] step_q;
	logic [7:0] target;
	logic [7:0] rate;
	logic [7:0] mapped;
	logic [4:0] offTime;
	logic [7:0] offInt;
	logic blinkOn;

	// Off fields; off level is zero without blink support
	assign offTime = offReg[7:3];
	assign offInt = CAN_BLINK ? {offReg[2:0], 5'h00} : RST_ZERO;
	assign blinkOn = CAN_BLINK && (onTime != RST_ZERO);

	// Intensity the sequencer aims at
	always_comb
	begin
		if (!blinkOn)
			target = dataLow ? onInt : offInt;
		else if (state_q == ON_PH)
			target = onInt;
		else
			target = offInt;
		rate = (target > cur_q) ? fadeIn : fadeOut;
	end

	// On/off sequencing in whole PWM periods
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= IDLE;
			timer_q <= RST_ZERO;
		end
		else if (!run || restart)
		begin
			state_q <= IDLE;
			timer_q <= RST_ZERO;
		end
		else
		begin
			case (state_q)
				IDLE:
					if (dataLow && blinkOn)
					begin
						state_q <= ON_PH;
						timer_q <= RST_ZERO;
					end
				ON_PH:
					if (!dataLow || !blinkOn)
						state_q <= IDLE;
					else if (periodTick)
					begin
						if (timer_q + 8'h01 >= onTime)
						begin
							// Single shot parks, blink repeats
							state_q <= (offTime == 5'h00) ? HOLD : OFF_PH;
							timer_q <= RST_ZERO;
						end
						else
							timer_q <= timer_q + 8'h01;
					end
				OFF_PH:
					if (!dataLow || !blinkOn)
						state_q <= IDLE;
					else if (periodTick)
					begin
						if (timer_q + 8'h01 >= {3'h0, offTime})
						begin
							state_q <= ON_PH;
							timer_q <= RST_ZERO;
						end
						else
							timer_q <= timer_q + 8'h01;
					end
				HOLD:
					if (!dataLow || !blinkOn)
						state_q <= IDLE;
				default:
					state_q <= IDLE;
			endcase
		end
	end

	// Ramp one level per rate LED ticks, or jump without fading
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cur_q <= RST_ZERO;
			step_q <= RST_ZERO;
		end
		else if (!run || restart)
		begin
			cur_q <= RST_ZERO;
			step_q <= RST_ZERO;
		end
		else if (!CAN_FADE || rate == RST_ZERO)
			cur_q <= target;
		else if (ledTick && cur_q != target)
		begin
			if (step_q + 8'h01 >= rate)
			begin
				step_q <= RST_ZERO;
				cur_q <= (target > cur_q) ? cur_q + 8'h01 : cur_q - 8'h01;
			end
			else
				step_q <= step_q + 8'h01;
		end
	end

	// Log mapping only on fade-capable channels
	assign mapped = (CAN_FADE && logMode) ? LOG_LUT[cur_q[7:1]] : cur_q;

	// PWM compare against the shared counter
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pwmOn <= 1'b0;
		else
			pwmOn <= run && (mapped > pwmCnt);
	end
endmodule : led_channel

// [src/gpio_led_top.sv]
/*
 * GPIO expander core: polarity, edge interrupts, clock management and
 * four LED drivers behind an APB slave.
 * Assumes pins are asynchronous; keypad signals come from same clock.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module gpio_led_top
	import led_gpio_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_IO-1:0] ioIn,
	output logic [NUM_IO-1:0] ioOut,
	input wire logic keyIrq,
	input wire logic keyEngineOn,
	input wire logic extResetN,
	input wire logic oscPinIn,
	output logic oscPinOut,
	output logic oscPinOe,
	output logic irqOutN,
	output logic irqOutNOe
);
	logic [NUM_IO-1:0] polQ, dataQ, maskQ, srcQ, evtQ, ledEnQ;
	logic [7:0] senseQ, clockQ, miscQ;
	logic [7:0] onTimeQ [NUM_IO];
	logic [7:0] onIntQ [NUM_IO];
	logic [7:0] offQ [NUM_IO];
	logic [7:0] riseQ [NUM_IO];
	logic [7:0] fallQ [NUM_IO];
	logic [NUM_IO-1:0] ioMeta, ioSync, prevQ, ioEff, edgeHit, pwmOn;
	logic [1:0] extMeta, extSync;
	logic extPrev;
	logic [5:0] idx;
	logic acc, wr, rd, mapped;
	logic [NUM_IO-1:0] srcD, evtD, clrMask;
	logic mainTick, ledTick, periodTick, ledRestart, ledClkOn;
	logic [6:0] ledDivQ;
	logic [7:0] pwmCntQ;
	logic [14:0] outDivQ;
	logic irqOeQ;
	logic [2:0] ledSel;

	// APB decode, zero wait states
	assign idx = paddr[7:2];
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign pready = 1'b1;
	always_comb
	begin
		mapped = (idx >= REG_POL && idx <= REG_LEDEN && idx != 6'h07);
		for (int i = 0; i < NUM_IO; i++)
			if (idx >= ON_BASE[i] && idx < ON_BASE[i] + 6'h05)
				mapped = 1'b1;
	end
	assign pslverr = acc && !mapped;

	// Two-flop synchronisers for all pin inputs
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ioMeta <= RST_ZERO[NUM_IO-1:0];
			ioSync <= RST_ZERO[NUM_IO-1:0];
			extMeta <= 2'h2; // Reset pin idle high, oscillator pin low
			extSync <= 2'h2;
		end
		else
		begin
			ioMeta <= ioIn;
			ioSync <= ioMeta;
			extMeta <= {extResetN, oscPinIn};
			extSync <= extMeta;
		end
	end

	// Polarity applied to the sampled inputs
	assign ioEff = ioSync ^ polQ;

	// Edge detection per two-bit sense code
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			prevQ <= RST_ZERO[NUM_IO-1:0];
		else
			prevQ <= ioEff;
	end
	always_comb
	begin
		for (int i = 0; i < NUM_IO; i++)
			edgeHit[i] = (senseQ[2*i] && ioEff[i] && !prevQ[i]) ||
				(senseQ[2*i+1] && !ioEff[i] && prevQ[i]);
	end

	// Clears: write-one to source, or data read with auto-clear
	always_comb
	begin
		clrMask = RST_ZERO[NUM_IO-1:0];
		if (wr && idx == REG_SRC)
			clrMask = pwdata[NUM_IO-1:0];
		if (rd && idx == REG_DATA && miscQ[MISC_AUTOCLR])
			clrMask = CLR_ALL[NUM_IO-1:0];
		// New edges win over a clear in the same cycle
		srcD = (srcQ & ~clrMask) | (edgeHit & ~maskQ);
		evtD = (evtQ & ~clrMask) | edgeHit;
	end

	// Flags and open-drain interrupt enable
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			srcQ <= RST_ZERO[NUM_IO-1:0];
			evtQ <= RST_ZERO[NUM_IO-1:0];
			irqOeQ <= 1'b0;
		end
		else
		begin
			srcQ <= srcD;
			evtQ <= evtD;
			irqOeQ <= (|srcD) || (keyIrq && keyEngineOn);
		end
	end
	assign irqOutN = 1'b0;
	assign irqOutNOe = irqOeQ;

	// Register writes
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			polQ <= RST_ZERO[NUM_IO-1:0];
			dataQ <= RST_ALL1[NUM_IO-1:0];
			maskQ <= RST_ALL1[NUM_IO-1:0];
			senseQ <= RST_ZERO;
			clockQ <= RST_ZERO;
			miscQ <= RST_ZERO;
			ledEnQ <= RST_ZERO[NUM_IO-1:0];
			for (int i = 0; i < NUM_IO; i++)
			begin
				onTimeQ[i] <= RST_ZERO;
				onIntQ[i] <= RST_ALL1;
				offQ[i] <= RST_ZERO;
				riseQ[i] <= RST_ZERO;
				fallQ[i] <= RST_ZERO;
			end
		end
		else if (wr)
		begin
			case (idx)
				REG_POL: polQ <= pwdata[NUM_IO-1:0];
				REG_DATA: dataQ <= pwdata[NUM_IO-1:0];
				REG_MASK: maskQ <= pwdata[NUM_IO-1:0];
				REG_SENSE: senseQ <= pwdata[7:0];
				REG_CLOCK: clockQ <= pwdata[7:0];
				REG_MISC: miscQ <= pwdata[7:0];
				REG_LEDEN: ledEnQ <= pwdata[NUM_IO-1:0];
				default: ;
			endcase
			// Blink and fade settings exist only where capable; on level on every I/O
			for (int i = 0; i < NUM_IO; i++)
			begin
				if (idx == ON_BASE[i] + 6'(SUB_ON) && BLINK_IO[i])
					onTimeQ[i] <= pwdata[7:0];
				if (idx == ON_BASE[i] + 6'(SUB_ONINT))
					onIntQ[i] <= pwdata[7:0];
				if (idx == ON_BASE[i] + 6'(SUB_OFF) && BLINK_IO[i])
					offQ[i] <= pwdata[7:0];
				if (idx == ON_BASE[i] + 6'(SUB_RISE) && FADE_IO[i])
					riseQ[i] <= pwdata[7:0];
				if (idx == ON_BASE[i] + 6'(SUB_FALL) && FADE_IO[i])
					fallQ[i] <= pwdata[7:0];
			end
		end
	end

	// Read mux; narrower registers sit in the low bits
	always_comb
	begin
		prdata = 32'h0000_0000;
		case (idx)
			REG_POL: prdata[NUM_IO-1:0] = polQ;
			REG_DATA: prdata[NUM_IO-1:0] = ioEff;
			REG_MASK: prdata[NUM_IO-1:0] = maskQ;
			REG_SENSE: prdata[7:0] = senseQ;
			REG_SRC: prdata[NUM_IO-1:0] = srcQ;
			REG_EVT: prdata[NUM_IO-1:0] = evtQ;
			REG_CLOCK: prdata[7:0] = clockQ;
			REG_MISC: prdata[7:0] = miscQ;
			REG_LEDEN: prdata[NUM_IO-1:0] = ledEnQ;
			default: ;
		endcase
		for (int i = 0; i < NUM_IO; i++)
		begin
			if (idx == ON_BASE[i] + 6'(SUB_ON))
				prdata[7:0] = onTimeQ[i];
			if (idx == ON_BASE[i] + 6'(SUB_ONINT))
				prdata[7:0] = onIntQ[i];
			if (idx == ON_BASE[i] + 6'(SUB_OFF))
				prdata[7:0] = offQ[i];
			if (idx == ON_BASE[i] + 6'(SUB_RISE))
				prdata[7:0] = riseQ[i];
			if (idx == ON_BASE[i] + 6'(SUB_FALL))
				prdata[7:0] = fallQ[i];
		end
	end

	// Main clock enable from internal or external source
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			extPrev <= 1'b0;
		else
			extPrev <= extSync[0];
	end
	always_comb
	begin
		case (clockQ[CLK_SRC_LO +: 2])
			SRC_INT: mainTick = 1'b1;
			SRC_EXT: mainTick = !clockQ[CLK_PIN_OUT] &&
				extSync[0] && !extPrev;
			default: mainTick = 1'b0;
		endcase
	end

	// Oscillator pin: input, divided clock, or fixed level output
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			outDivQ <= 15'h0000;
			oscPinOut <= 1'b0;
		end
		else if (clockQ[CLK_DIV_LO +: 4] == DIV_LOW)
			oscPinOut <= 1'b0;
		else if (clockQ[CLK_DIV_LO +: 4] == DIV_HIGH)
			oscPinOut <= 1'b1;
		else if (mainTick)
		begin
			if (outDivQ == (15'h0001 << (clockQ[CLK_DIV_LO +: 4] - 4'h1))
				- 15'h0001)
			begin
				outDivQ <= 15'h0000;
				oscPinOut <= !oscPinOut;
			end
			else
				outDivQ <= outDivQ + 15'h0001;
		end
	end
	assign oscPinOe = clockQ[CLK_PIN_OUT];

	// Shared LED clock: off, or main clock over 2^(sel-1)
	assign ledSel = miscQ[MISC_CLK_LO +: 3];
	assign ledClkOn = (ledSel != 3'h0);
	assign ledRestart = miscQ[MISC_RSTEN] && !extSync[1];
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ledDivQ <= 7'h00;
		else if (ledRestart || !ledClkOn)
			ledDivQ <= 7'h00;
		else if (mainTick)
			ledDivQ <= ledDivQ + 7'h01;
	end
	assign ledTick = mainTick && ledClkOn && !ledRestart &&
		((ledDivQ & ((7'h01 << (ledSel - 3'h1)) - 7'h01)) == 7'h00);

	// Shared 8-bit PWM counter
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pwmCntQ <= RST_ZERO;
		else if (ledRestart)
			pwmCntQ <= RST_ZERO;
		else if (ledTick)
			pwmCntQ <= pwmCntQ + 8'h01;
	end
	assign periodTick = ledTick && (pwmCntQ == RST_ALL1);

	// One driver per I/O with its own capabilities
	for (genvar g = 0; g < NUM_IO; g++)
	begin : gen_led
		led_channel #(
			.CAN_BLINK(BLINK_IO[g]),
			.CAN_FADE(FADE_IO[g])
		) u_chan (
			.core_clk(core_clk),
			.arst_n(arst_n),
			.restart(ledRestart),
			.ledTick(ledTick),
			.periodTick(periodTick),
			.run(ledClkOn && ledEnQ[g]),
			.dataLow(!dataQ[g]),
			.onTime(onTimeQ[g]),
			.onInt(onIntQ[g]),
			.offReg(offQ[g]),
			.fadeIn(riseQ[g]),
			.fadeOut(fallQ[g]),
			.logMode(miscQ[MISC_LOG]),
			.pwmCnt(pwmCntQ),
			.pwmOn(pwmOn[g])
		);
	end

	// Pin drive: LED sinks when on; driver output is inverted, polarity applies only to plain data
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ioOut <= RST_ALL1[NUM_IO-1:0];
		else
			for (int i = 0; i < NUM_IO; i++)
				ioOut[i] <= (ledClkOn && ledEnQ[i]) ? !pwmOn[i]
					: dataQ[i] ^ polQ[i];
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	a_data_polar: assert property (
		rd && idx == REG_DATA |-> prdata[NUM_IO-1:0] == (ioSync ^ polQ))
		else $error("data read ignores polarity");
	a_masked_quiet: assert property (
		maskQ == RST_ALL1[NUM_IO-1:0] && srcQ == '0 |=> srcQ == '0)
		else $error("masked I/O raised a source flag");
	a_irq_follow: assert property (
		(|srcQ) |-> irqOutNOe && !irqOutN)
		else $error("pending source without interrupt");
	a_src_record: assert property (
		|(edgeHit & ~maskQ) |=> (srcQ & $past(edgeHit & ~maskQ))
			== $past(edgeHit & ~maskQ))
		else $error("edge not recorded in source");
	a_w1c_clear: assert property (
		wr && idx == REG_SRC && pwdata[7:0] == CLR_ALL && edgeHit == '0 &&
			!(keyIrq && keyEngineOn)
			|=> srcQ == '0 && evtQ == '0 && !irqOutNOe)
		else $error("clear by write failed");
	a_read_clear: assert property (
		rd && idx == REG_DATA && miscQ[MISC_AUTOCLR] && edgeHit == '0
			|=> srcQ == '0)
		else $error("auto clear on data read failed");
	a_rise_only: assert property (
		senseQ[1:0] == EDGE_RISE && $fell(ioEff[0]) |-> !edgeHit[0])
		else $error("falling edge seen under rising sense");
	a_key_irq: assert property (
		keyIrq && keyEngineOn |=> irqOutNOe)
		else $error("keypad press not on interrupt");
	a_no_osc: assert property (
		clockQ[CLK_SRC_LO +: 2] == SRC_OFF |-> !ledTick && !mainTick)
		else $error("LED clock runs without main clock");
	a_led_off: assert property (
		ledSel == 3'h0 |=> $stable(pwmCntQ))
		else $error("PWM counter moves with LED clock off");
	a_restart: assert property (
		ledRestart |=> pwmCntQ == RST_ZERO && ledDivQ == 7'h00)
		else $error("reset pin did not restart LED counters");
endmodule : gpio_led_top

// [tb/apb_host_model.sv]
/*
 * Host side of the register port: APB master transfers and the
 * host duties of the interrupt and LED start sequence.
 * Assumes one rising-edge clock shared with the slave.
 */
`timescale 1ns/1ps
module apb_host_model
	import led_gpio_pkg::*;
(
	input wire logic core_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	// Idle bus from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// One transfer: setup, then access held until pready
	task automatic xfer(input logic wr, input logic [5:0] idx,
		input logic [7:0] val, output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, val};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// Clear pending interrupt by writing all ones
	task automatic clearIrq;
		logic [31:0] d;
		logic e;
		xfer(1'b1, REG_SRC, CLR_ALL, d, e);
	endtask : clearIrq

	// Start or stop drivers; data control inverted under polarity
	task automatic setLedRun(input logic [3:0] runMask,
		input logic [3:0] pol);
		logic [31:0] d;
		logic e;
		xfer(1'b1, REG_DATA, {4'h0, ~runMask ^ pol}, d, e);
	endtask : setLedRun
endmodule : apb_host_model

// [tb/gpio_led_driver_irq_clock_test.sv]
/*
 * Self-checking bench: reset values, edge interrupts, auto clear,
 * polarity, keypad OR, oscillator pin and PWM duty.
 * Assumes apb_host_model drives the register port.
 */
`timescale 1ns/1ps
module gpio_led_driver_irq_clock_test;
	import led_gpio_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [3:0] ioIn = 4'h0;
	logic [3:0] ioOut;
	logic keyIrq = 1'b0;
	logic keyEngineOn = 1'b0;
	logic extResetN = 1'b1;
	logic oscPinIn = 1'b0;
	logic oscPinOut, oscPinOe, irqOutN, irqOutNOe, err;
	int failures = 0;
	int nTests = 0;
	int cycles = 0;
	logic extRun = 1'b0;
	int ledFlips = 0;
	logic lastOut;

	// Clock and watchdog
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	// External oscillator: toggles each cycle once enabled
	always @(posedge core_clk)
		if (extRun)
			oscPinIn <= ~oscPinIn;

	apb_host_model host (.core_clk(core_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));
	gpio_led_top uut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ioIn(ioIn), .ioOut(ioOut), .keyIrq(keyIrq),
		.keyEngineOn(keyEngineOn), .extResetN(extResetN),
		.oscPinIn(oscPinIn), .oscPinOut(oscPinOut), .oscPinOe(oscPinOe),
		.irqOutN(irqOutN), .irqOutNOe(irqOutNOe));

	// Compare and count
	task automatic check(input string what, input logic [31:0] expv,
		input logic [31:0] got);
		nTests++;
		if (got !== expv)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, expv, got);
		end
	endtask : check

	// Register access shorthands
	task automatic wr(input logic [5:0] idx, input logic [7:0] v);
		host.xfer(1'b1, idx, v, rdv, err);
	endtask : wr
	task automatic rdChk(input string what, input logic [5:0] idx,
		input logic [7:0] expv);
		host.xfer(1'b0, idx, 8'h00, rdv, err);
		check(what, {24'h00_0000, expv}, rdv);
	endtask : rdChk

	// Bounded wait for the interrupt pin level, then judge it
	task automatic waitIrq(input logic lvl);
		int n;
		n = 0;
		while (irqOutNOe !== lvl && n < 12)
		begin
			@(posedge core_clk);
			n++;
		end
		check("irqOutNOe", {31'h0, lvl}, {31'h0, irqOutNOe});
	endtask : waitIrq

	task automatic setPins(input logic [3:0] v);
		@(posedge core_clk);
		ioIn <= v;
		repeat (6) @(posedge core_clk);
	endtask : setPins

	task automatic testReset;
		check("ioOut", 32'h0000_000F, {28'h0, ioOut});
		check("irq released", 32'h0, {31'h0, irqOutNOe});
		rdChk("mask", REG_MASK, 8'h0F);
		rdChk("src", REG_SRC, 8'h00);
		rdChk("evt", REG_EVT, 8'h00);
		rdChk("misc", REG_MISC, 8'h00);
		rdChk("onint", ON_BASE[0] + 6'(SUB_ONINT), 8'hFF);
		rdChk("unmapped", 6'h07, 8'h00);
		check("pslverr", 32'h1, {31'h0, err});
		$display("reset test done");
	endtask : testReset

	task automatic testEdge;
		wr(REG_MASK, 8'h0D);
		wr(REG_SENSE, {4'h0, EDGE_RISE, EDGE_RISE});
		setPins(4'h3);
		waitIrq(1'b1);
		check("irq pin low", 32'h0, {31'h0, irqOutN});
		rdChk("src", REG_SRC, 8'h02);
		rdChk("evt", REG_EVT, 8'h03);
		host.clearIrq();
		waitIrq(1'b0);
		rdChk("evt cleared", REG_EVT, 8'h00);
		setPins(4'h1);
		check("no fall irq", 32'h0, {31'h0, irqOutNOe});
		$display("edge test done");
	endtask : testEdge

	task automatic testAutoClear;
		wr(REG_MISC, 8'h01);
		wr(REG_SENSE, {4'h0, EDGE_FALL, 2'h0});
		setPins(4'h3);
		setPins(4'h1);
		waitIrq(1'b1);
		wr(REG_POL, 8'h05);
		rdChk("data pol", REG_DATA, 8'h04);
		waitIrq(1'b0);
		wr(REG_POL, 8'h00);
		wr(REG_MISC, 8'h00);
		$display("auto clear test done");
	endtask : testAutoClear

	task automatic testKeypad;
		@(posedge core_clk);
		keyIrq <= 1'b1;
		repeat (6) @(posedge core_clk);
		check("key off", 32'h0, {31'h0, irqOutNOe});
		keyEngineOn <= 1'b1;
		waitIrq(1'b1);
		keyIrq <= 1'b0;
		waitIrq(1'b0);
		$display("keypad test done");
	endtask : testKeypad

	task automatic testOsc;
		int flips;
		logic last;
		wr(REG_CLOCK, {3'h0, 1'b1, DIV_HIGH});
		repeat (4) @(posedge core_clk);
		check("oe", 32'h1, {31'h0, oscPinOe});
		check("gpo high", 32'h1, {31'h0, oscPinOut});
		wr(REG_CLOCK, {3'h0, 1'b1, DIV_LOW});
		repeat (4) @(posedge core_clk);
		check("gpo low", 32'h0, {31'h0, oscPinOut});
		// Divider 2: pin toggles every two main ticks
		wr(REG_CLOCK, {1'b0, SRC_INT, 1'b1, 4'h2});
		repeat (8) @(posedge core_clk);
		flips = 0;
		last = oscPinOut;
		repeat (40)
		begin
			@(posedge core_clk);
			if (oscPinOut !== last)
				flips++;
			last = oscPinOut;
		end
		check("div flips", 32'h0000_0014, 32'(flips));
		wr(REG_CLOCK, {1'b0, SRC_INT, 1'b0, DIV_LOW});
		repeat (4) @(posedge core_clk);
		check("pin input", 32'h0, {31'h0, oscPinOe});
		$display("osc test done");
	endtask : testOsc

	// Count LED-on (low) cycles and level changes of I/O0 in a window
	task automatic countOn(input int expv, input int win);
		int lows;
		lows = 0;
		ledFlips = 0;
		repeat (600) @(posedge core_clk);
		lastOut = ioOut[0];
		repeat (win)
		begin
			@(posedge core_clk);
			if (ioOut[0] === 1'b0)
				lows++;
			if (ioOut[0] !== lastOut)
				ledFlips++;
			lastOut = ioOut[0];
		end
		check("on cycles", 32'(expv), 32'(lows));
	endtask : countOn

	task automatic testPwm;
		wr(REG_MISC, 8'h10);
		wr(ON_BASE[0] + 6'(SUB_ONINT), 8'h80);
		wr(REG_LEDEN, 8'h01);
		host.setLedRun(4'h1, 4'h0);
		countOn(256, 512);
		check("pwm edges", 32'h0000_0004, 32'(ledFlips));
		// Blink one period on, one off; then single shot parks dark
		wr(ON_BASE[0] + 6'(SUB_OFF), 8'h08);
		wr(ON_BASE[0] + 6'(SUB_ON), 8'h01);
		countOn(512, 2048);
		wr(ON_BASE[0] + 6'(SUB_OFF), 8'h00);
		countOn(0, 512);
		// Reset pin holds the LED counters, registers survive
		wr(ON_BASE[0] + 6'(SUB_ON), 8'h00);
		wr(REG_MISC, 8'h14);
		extResetN <= 1'b0;
		countOn(0, 512);
		extResetN <= 1'b1;
		countOn(256, 512);
		rdChk("regs kept", ON_BASE[0] + 6'(SUB_ONINT), 8'h80);
		// External clock at half rate halves the PWM frequency
		wr(REG_MISC, 8'h10);
		wr(REG_CLOCK, {1'b0, SRC_EXT, 1'b0, 4'h0});
		extRun <= 1'b1;
		countOn(512, 1024);
		check("ext pwm edges", 32'h0000_0004, 32'(ledFlips));
		host.setLedRun(4'h0, 4'h0);
		countOn(0, 512);
		$display("pwm test done");
	endtask : testPwm

	task give_verdict;
		$display("comparisons %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// Main sequence
	initial
	begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		testReset();
		testEdge();
		testAutoClear();
		testKeypad();
		testOsc();
		testPwm();
		give_verdict();
	end
endmodule : gpio_led_driver_irq_clock_test
